// file: hw/mpo_latch_bank.sv
// Purpose: Eight set/clear output latches driven by strobe writes.
// Assumes: Set and clear pulses never arrive in the same cycle.
// Notes:   Held bits ignore both strobes and keep their state.
`timescale 1ns/10ps
`default_nettype none
module mpo_latch_bank
    import mpo_pkg::*;
(
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst,
    // Latch carrier
    mpo_latch_if.bank  lat
);

    mpo_byte_t assertedQ;
    mpo_byte_t assertedD;
    mpo_byte_t setOk;
    mpo_byte_t clearOk;

    assign setOk     = lat.setPulse & ~lat.hold;
    assign clearOk   = lat.clearPulse & ~lat.hold;
    // Only a clear strobe or reset can negate an asserted latch
    assign assertedD = (assertedQ | setOk) & ~clearOk;

    always_ff @(posedge clk) begin
        if (rst) begin
            assertedQ <= LATCH_RESET;
        end else begin
            assertedQ <= assertedD;
        end
    end

    assign lat.asserted = assertedQ;

endmodule // mpo_latch_bank
`default_nettype wire

// file: hw/mpo_latch_if.sv
// Purpose: Carries strobes and latch state between control and latch bank.
// Assumes: One clock domain.
// Notes:   hold masks outputs taken by an alternate function.
`timescale 1ns/10ps
`default_nettype none
interface mpo_latch_if;
    logic [7:0] setPulse;
    logic [7:0] clearPulse;
    logic [7:0] hold;
    logic [7:0] asserted;

    modport ctrl (
        output setPulse,
        output clearPulse,
        output hold,
        input  asserted
    );

    modport bank (
        input  setPulse,
        input  clearPulse,
        input  hold,
        output asserted
    );
endinterface
`default_nettype wire

// file: hw/mpo_output_port.sv
// Purpose: Eight multipurpose outputs with strobe or alternate sources.
// Assumes: Alternate sources are logic on the same clock as clk.
// Notes:   Pins are registered, so every source reaches its pin one cycle late.
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
module mpo_output_port
    import mpo_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Register port
    input  wire mpo_pkg::mpo_addr_t regAddr,
    input  wire mpo_pkg::mpo_byte_t regWrData,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output mpo_pkg::mpo_byte_t     regRdData,
    // Alternate sources
    input  wire logic              txAClockX16,
    input  wire logic              txAClockX1,
    input  wire logic              rxAClockX1,
    input  wire logic              txBClockX1,
    input  wire logic              rxBClockX1,
    input  wire logic              timerOut,
    input  wire logic              rxAReady,
    input  wire logic              rxBReady,
    input  wire logic              txAReady,
    input  wire logic              txBReady,
    // Pins, low = asserted
    output mpo_pkg::mpo_byte_t     generalOutputs
);

    ////////////////////////////////////////////////////////////////////////
    // Register decode
    mpo_byte_t sourceConfigQ;
    mpo_byte_t aModeOneQ;
    mpo_byte_t aModeTwoQ;
    mpo_byte_t bModeOneQ;
    mpo_byte_t bModeTwoQ;
    mpo_byte_t pinQ;
    mpo_byte_t pinD;
    mpo_byte_t rdDataQ;
    mpo_byte_t rdDataD;
    logic      wrConfig;
    logic      wrAModeOne;
    logic      wrAModeTwo;
    logic      wrBModeOne;
    logic      wrBModeTwo;
    logic      wrACommand;
    logic      wrBCommand;
    logic      wrSet;
    logic      wrClear;
    logic      rtsAAsserted;
    logic      rtsBAsserted;

    assign wrConfig   = regWrite && (regAddr == OFS_SOURCE_CONFIG);
    assign wrAModeOne = regWrite && (regAddr == OFS_A_MODE_ONE);
    assign wrAModeTwo = regWrite && (regAddr == OFS_A_MODE_TWO);
    assign wrBModeOne = regWrite && (regAddr == OFS_B_MODE_ONE);
    assign wrBModeTwo = regWrite && (regAddr == OFS_B_MODE_TWO);
    assign wrACommand = regWrite && (regAddr == OFS_A_COMMAND);
    assign wrBCommand = regWrite && (regAddr == OFS_B_COMMAND);
    assign wrSet      = regWrite && (regAddr == OFS_SET_STROBE);
    assign wrClear    = regWrite && (regAddr == OFS_CLEAR_STROBE);

    always_ff @(posedge clk) begin
        if (rst) begin
            sourceConfigQ <= CFG_RESET;
            aModeOneQ     <= MODE_RESET;
            aModeTwoQ     <= MODE_RESET;
            bModeOneQ     <= MODE_RESET;
            bModeTwoQ     <= MODE_RESET;
        end else begin
            if (wrConfig)   sourceConfigQ <= regWrData;
            if (wrAModeOne) aModeOneQ     <= regWrData;
            if (wrAModeTwo) aModeTwoQ     <= regWrData;
            if (wrBModeOne) bModeOneQ     <= regWrData;
            if (wrBModeTwo) bModeTwoQ     <= regWrData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source selection
    mpo_sel_t  out2Sel;
    mpo_sel_t  out3Sel;
    logic      rtsSelA;
    logic      rtsSelB;
    logic      out2Alt;
    logic      out3Alt;
    logic      out2Level;
    logic      out3Level;
    logic      out2Src;
    logic      out3Src;
    logic [3:0] readyAlt;
    logic [3:0] readyLevel;
    mpo_byte_t altMask;
    mpo_byte_t strobeLevel;

    // Either mode bit hands output 0 or 1 to request-to-send
    assign rtsSelA = aModeOneQ[MODE_ONE_RTS_BIT]
                   | aModeTwoQ[MODE_TWO_RTS_BIT];
    assign rtsSelB = bModeOneQ[MODE_ONE_RTS_BIT]
                   | bModeTwoQ[MODE_TWO_RTS_BIT];

    assign out2Sel = mpo_sel_t'(sourceConfigQ[CFG_OUT2_LSB +: 2]);
    assign out3Sel = mpo_sel_t'(sourceConfigQ[CFG_OUT3_LSB +: 2]);
    assign out2Alt = (out2Sel != MPO_SRC_STROBE);
    assign out3Alt = (out3Sel != MPO_SRC_STROBE);
    assign readyAlt = sourceConfigQ[CFG_READY_LSB +: 4];

    assign out2Src = (out2Sel == MPO_SRC_ALT_ONE) ? txAClockX16 :
                     (out2Sel == MPO_SRC_ALT_TWO) ? txAClockX1  :
                     rxAClockX1;
    // Timer is taken as is; starting it first is software's duty
    assign out3Src = (out3Sel == MPO_SRC_ALT_ONE) ? timerOut   :
                     (out3Sel == MPO_SRC_ALT_TWO) ? txBClockX1 :
                     rxBClockX1;
    assign readyLevel = {~txBReady, ~txAReady, ~rxBReady, ~rxAReady};

    assign altMask = {readyAlt, out3Alt, out2Alt, rtsSelB, rtsSelA};

    ////////////////////////////////////////////////////////////////////////
    // Strobe latches and request-to-send latches
    mpo_latch_if latchBus ();

    assign latchBus.setPulse   = wrSet   ? regWrData : READ_ZERO;
    assign latchBus.clearPulse = wrClear ? regWrData : READ_ZERO;
    assign latchBus.hold       = altMask;

    mpo_latch_bank u_latch_bank (
        .clk (clk),
        .rst (rst),
        .lat (latchBus)
    );

    mpo_rts_latch u_rts_a (
        .clk      (clk),
        .rst      (rst),
        .cmdWrite (wrACommand),
        .cmdCode  (regWrData[CMD_CODE_LSB +: 4]),
        .asserted (rtsAAsserted)
    );

    mpo_rts_latch u_rts_b (
        .clk      (clk),
        .rst      (rst),
        .cmdWrite (wrBCommand),
        .cmdCode  (regWrData[CMD_CODE_LSB +: 4]),
        .asserted (rtsBAsserted)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin levels
    assign strobeLevel = ~latchBus.asserted;
    assign out2Level   = out2Alt ? out2Src : strobeLevel[2];
    assign out3Level   = out3Alt ? out3Src : strobeLevel[3];

    assign pinD[0] = rtsSelA ? ~rtsAAsserted : strobeLevel[0];
    assign pinD[1] = rtsSelB ? ~rtsBAsserted : strobeLevel[1];
    assign pinD[2] = out2Level;
    assign pinD[3] = out3Level;
    assign pinD[7:4] = (readyAlt & readyLevel)
                     | (~readyAlt & strobeLevel[7:4]);

    always_ff @(posedge clk) begin
        if (rst) begin
            pinQ <= PIN_RESET;
        end else begin
            pinQ <= pinD;
        end
    end

    assign generalOutputs = pinQ;

    ////////////////////////////////////////////////////////////////////////
    // Read data, valid only in the cycle after the read strobe
    mpo_byte_t rdSel;

    assign rdSel = (regAddr == OFS_A_MODE_ONE)  ? aModeOneQ :
                   (regAddr == OFS_A_MODE_TWO)  ? aModeTwoQ :
                   (regAddr == OFS_B_MODE_ONE)  ? bModeOneQ :
                   (regAddr == OFS_B_MODE_TWO)  ? bModeTwoQ :
                   (regAddr == OFS_PIN_STATE)   ? pinQ      :
                   (regAddr == OFS_LATCH_STATE) ? latchBus.asserted :
                   READ_ZERO;
    assign rdDataD = regRead ? rdSel : READ_ZERO;

    always_ff @(posedge clk) begin
        if (rst) begin
            rdDataQ <= READ_ZERO;
        end else begin
            rdDataQ <= rdDataD;
        end
    end

    assign regRdData = rdDataQ;

endmodule // mpo_output_port
`default_nettype wire

// file: hw/mpo_pkg.sv
// Purpose: Shared constants and types of the multipurpose output port.
// Assumes: 8-bit register data, 4-bit register address.
// Notes:   Latch state 1 means the pin is asserted, i.e. driven low.
package mpo_pkg;

    typedef logic [7:0] mpo_byte_t;
    typedef logic [3:0] mpo_addr_t;

    // Output source select codes for outputs 2 and 3
    typedef enum logic [1:0] {
        MPO_SRC_STROBE,
        MPO_SRC_ALT_ONE,
        MPO_SRC_ALT_TWO,
        MPO_SRC_ALT_THREE
    } mpo_sel_t;

    // Register offsets
    localparam mpo_addr_t OFS_SOURCE_CONFIG = 4'h0;
    localparam mpo_addr_t OFS_A_MODE_ONE    = 4'h1;
    localparam mpo_addr_t OFS_A_MODE_TWO    = 4'h2;
    localparam mpo_addr_t OFS_B_MODE_ONE    = 4'h3;
    localparam mpo_addr_t OFS_B_MODE_TWO    = 4'h4;
    localparam mpo_addr_t OFS_A_COMMAND     = 4'h5;
    localparam mpo_addr_t OFS_B_COMMAND     = 4'h6;
    localparam mpo_addr_t OFS_PIN_STATE     = 4'h8;
    localparam mpo_addr_t OFS_LATCH_STATE   = 4'h9;
    localparam mpo_addr_t OFS_SET_STROBE    = 4'hE;
    localparam mpo_addr_t OFS_CLEAR_STROBE  = 4'hF;

    // Field positions
    localparam int MODE_ONE_RTS_BIT = 7;
    localparam int MODE_TWO_RTS_BIT = 5;
    localparam int CMD_CODE_LSB     = 4;
    localparam int CFG_OUT2_LSB     = 0;
    localparam int CFG_OUT3_LSB     = 2;
    localparam int CFG_READY_LSB    = 4;

    // Command codes in command bits 7:4
    localparam logic [3:0] CMD_RTS_ASSERT = 4'h8;
    localparam logic [3:0] CMD_RTS_NEGATE = 4'h9;

    // Reset values
    localparam mpo_byte_t CFG_RESET   = 8'h00;
    localparam mpo_byte_t MODE_RESET  = 8'h00;
    localparam mpo_byte_t LATCH_RESET = 8'h00;
    localparam mpo_byte_t PIN_RESET   = 8'hFF;
    localparam mpo_byte_t READ_ZERO   = 8'h00;

endpackage

// file: hw/mpo_rts_latch.sv
// Purpose: Request-to-send latch steered by channel command writes.
// Assumes: Command write is a one-cycle strobe.
// Notes:   Codes other than assert and negate leave the latch alone.
`timescale 1ns/10ps
`default_nettype none
module mpo_rts_latch
    import mpo_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Command
    input  wire logic       cmdWrite,
    input  wire logic [3:0] cmdCode,
    // State, 1 = asserted (pin low)
    output logic            asserted
);

    logic assertedQ;
    logic assertedD;
    logic doAssert;
    logic doNegate;

    assign doAssert  = cmdWrite && (cmdCode == CMD_RTS_ASSERT);
    assign doNegate  = cmdWrite && (cmdCode == CMD_RTS_NEGATE);
    assign assertedD = doAssert ? 1'b1 : (doNegate ? 1'b0 : assertedQ);

    always_ff @(posedge clk) begin
        if (rst) begin
            assertedQ <= 1'b0;
        end else begin
            assertedQ <= assertedD;
        end
    end

    assign asserted = assertedQ;

endmodule // mpo_rts_latch
`default_nettype wire

// file: sim/mpo_output_port_props.sv
// Purpose: Port checks of the multipurpose output port.
// Assumes: Channel A mode two register is never written.
// Notes:   Pins lag a register write by two cycles.
`timescale 1ns/10ps
`default_nettype none
module mpo_output_port_props
    import mpo_pkg::*;
(
    // Clock and reset
    input wire logic               clk,
    input wire logic               rst,
    // Register port
    input wire mpo_pkg::mpo_addr_t regAddr,
    input wire mpo_pkg::mpo_byte_t regWrData,
    input wire logic               regWrite,
    // Sources and pins
    input wire logic               txAClockX1,
    input wire logic               timerOut,
    input wire logic               rxAReady,
    input wire mpo_pkg::mpo_byte_t generalOutputs
);
    wire       wSet = regWrite && regAddr == OFS_SET_STROBE;
    wire       wClr = regWrite && regAddr == OFS_CLEAR_STROBE;
    wire       wCmd = regWrite && regAddr == OFS_A_COMMAND;
    wire       clr5 = wClr && regWrData[5];
    wire [3:0] code = regWrData[7:4];
    mpo_byte_t cfg_q;
    logic      rtsOn_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q <= 8'h00;
            rtsOn_q <= 1'b0;
        end else if (regWrite && regAddr == OFS_SOURCE_CONFIG) begin
            cfg_q <= regWrData;
        end else if (regWrite && regAddr == OFS_A_MODE_ONE) begin
            rtsOn_q <= regWrData[7];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    reset_high_a: assert property (disable iff (1'b0)
        rst |=> generalOutputs == 8'hFF) else $error("pins not high");
    set_low_a: assert property (
        wSet && regWrData[7] && !cfg_q[7] |=> ##1 !generalOutputs[7])
        else $error("set did not assert");
    clear_high_a: assert property (
        wClr && regWrData[2] && cfg_q[1:0] == 2'b00 |=> ##1 generalOutputs[2])
        else $error("clear did not negate");
    rise_cause_a: assert property (
        $rose(generalOutputs[5]) && !$past(rst) |->
        $past(clr5, 2) || $past(cfg_q[5]) || $past(cfg_q[5], 2))
        else $error("pin negated without clear");
    out2_clock_a: assert property (
        cfg_q[1:0] == 2'b10 |=> generalOutputs[2] == $past(txAClockX1))
        else $error("pin 2 source wrong");
    out3_timer_a: assert property (
        cfg_q[3:2] == 2'b01 |=> generalOutputs[3] == $past(timerOut))
        else $error("pin 3 source wrong");
    out4_ready_a: assert property (
        cfg_q[4] |=> generalOutputs[4] == !$past(rxAReady))
        else $error("pin 4 source wrong");
    rts_assert_a: assert property (
        wCmd && rtsOn_q && code == CMD_RTS_ASSERT |=> ##1 !generalOutputs[0])
        else $error("rts not asserted");
    rts_negate_a: assert property (
        wCmd && rtsOn_q && code == CMD_RTS_NEGATE |=> ##1 generalOutputs[0])
        else $error("rts not negated");
    cover property (wSet && regWrData[7]);
    cover property (wCmd && rtsOn_q);
    cover property (cfg_q[3:2] == 2'b01);
endmodule // mpo_output_port_props
bind mpo_output_port mpo_output_port_props u_props (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .txAClockX1(txAClockX1), .timerOut(timerOut),
    .rxAReady(rxAReady), .generalOutputs(generalOutputs));
`default_nettype wire

// file: sim/mpo_output_port_tb.sv
// Purpose: Self-checking bench of the multipurpose output port.
// Assumes: Bus calls start just after a rising edge.
// Notes:   Each write leaves one idle cycle behind it.
`timescale 1ns/10ps
`default_nettype none
module mpo_output_port_tb;
    import mpo_pkg::*;
    logic      clk = 1'b0;
    logic      rst = 1'b1;
    mpo_addr_t regAddr = 4'h0;
    mpo_byte_t regWrData = 8'h00;
    logic      regWrite = 1'b0;
    logic      regRead = 1'b0;
    mpo_byte_t regRdData;
    mpo_byte_t generalOutputs;
    wire [9:0] src;
    int        failures = 0;
    int        compares = 0;
    mpo_byte_t e;
    mpo_byte_t cfgList [4] = '{8'h06, 8'hF9, 8'h5F, 8'hA0};
    initial begin
        forever #5 clk = ~clk;
    end
    mpo_source_model MODEL (.clk(clk), .rst(rst), .src(src));
    mpo_output_port DUT (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .txAClockX16(src[0]), .txAClockX1(src[1]), .rxAClockX1(src[2]),
        .txBClockX1(src[3]), .rxBClockX1(src[4]), .timerOut(src[5]),
        .rxAReady(src[6]), .rxBReady(src[7]), .txAReady(src[8]),
        .txBReady(src[9]), .generalOutputs(generalOutputs));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input mpo_byte_t got, input mpo_byte_t exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input mpo_addr_t a, input mpo_byte_t d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input mpo_addr_t a, input mpo_byte_t x);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        chk(regRdData, x);
        @(posedge clk);
    endtask
    // Pins settle one edge after the write edge
    task automatic wp(input mpo_addr_t a, input mpo_byte_t d, mpo_byte_t x);
        wr(a, d);
        @(negedge clk);
        chk(generalOutputs, x);
        @(posedge clk);
    endtask
    function automatic mpo_byte_t expPins(input mpo_byte_t c, mpo_byte_t l);
        mpo_byte_t  r;
        logic [3:0] a;
        logic [3:0] b;
        r = ~l;
        a = {src[2], src[1], src[0], r[2]};
        b = {src[4], src[3], src[5], r[3]};
        r[2] = a[c[1:0]];
        r[3] = b[c[3:2]];
        for (int i = 4; i < 8; i++) begin
            if (c[i]) begin
                r[i] = ~src[i + 2];
            end
        end
        return r;
    endfunction
    task automatic stop_test();
        $display("compares %0d, failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(OFS_PIN_STATE, 8'hFF);
        rd(OFS_LATCH_STATE, 8'h00);
        rd(4'h7, 8'h00);
        wp(OFS_SET_STROBE, 8'hA5, 8'h5A);
        wp(OFS_SET_STROBE, 8'h00, 8'h5A);
        wp(OFS_A_COMMAND, 8'h90, 8'h5A);
        wp(OFS_CLEAR_STROBE, 8'h05, 8'h5F);
        foreach (cfgList[k]) begin
            wr(OFS_SOURCE_CONFIG, cfgList[k]);
            @(negedge clk);
            e = expPins(cfgList[k], 8'hA0);
            repeat (40) begin
                @(negedge clk);
                chk(generalOutputs, e);
                e = expPins(cfgList[k], 8'hA0);
            end
            @(posedge clk);
        end
        wr(OFS_SOURCE_CONFIG, 8'hFF);
        wr(OFS_SET_STROBE, 8'hFF);
        wr(OFS_CLEAR_STROBE, 8'hFC);
        rd(OFS_LATCH_STATE, 8'hA3);
        wp(OFS_SOURCE_CONFIG, 8'h00, 8'h5C);
        rd(OFS_SOURCE_CONFIG, 8'h00);
        wp(OFS_A_MODE_ONE, 8'h93, 8'h5D);
        rd(OFS_A_MODE_ONE, 8'h93);
        wp(OFS_A_COMMAND, 8'h80, 8'h5C);
        wp(OFS_CLEAR_STROBE, 8'h01, 8'h5C);
        wp(OFS_A_COMMAND, 8'h50, 8'h5C);
        wp(OFS_A_COMMAND, 8'h90, 8'h5D);
        wp(OFS_SET_STROBE, 8'h01, 8'h5D);
        wp(OFS_A_MODE_ONE, 8'h00, 8'h5C);
        wp(OFS_B_MODE_TWO, 8'h20, 8'h5E);
        rd(OFS_B_MODE_TWO, 8'h20);
        wp(OFS_B_COMMAND, 8'h80, 8'h5C);
        wp(OFS_CLEAR_STROBE, 8'h02, 8'h5C);
        wp(OFS_B_COMMAND, 8'h90, 8'h5E);
        wp(OFS_B_MODE_TWO, 8'h00, 8'h5C);
        wp(OFS_LATCH_STATE, 8'hFF, 8'h5C);
        rd(OFS_LATCH_STATE, 8'hA3);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(OFS_PIN_STATE, 8'hFF);
        rd(OFS_LATCH_STATE, 8'h00);
        stop_test();
    end
    // About 270 cycles of tests; fifteen times that means a hang
    initial begin
        repeat (4000) @(posedge clk);
        failures++;
        stop_test();
    end
endmodule // mpo_output_port_tb
`default_nettype wire

// file: sim/mpo_source_model.sv
// Purpose: Alternate sources seen by the output port.
// Assumes: All sources run on clk.
// Notes:   Order: x16, txA x1, rxA x1, txB x1, rxB x1, timer, 4 ready.
`timescale 1ns/10ps
`default_nettype none
module mpo_source_model (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst,
    // Sources
    output logic  [9:0] src
);
    logic [7:0] cnt_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    // Timer runs from reset, so it is set up before the port picks it
    assign src[5:0] = {cnt_q[5], cnt_q[1], cnt_q[2], cnt_q[3], cnt_q[4],
                       cnt_q[0]};
    assign src[9:6] = {cnt_q[6:5] ^ cnt_q[1:0], cnt_q[3] ^ cnt_q[0],
                       cnt_q[2]};
endmodule // mpo_source_model
`default_nettype wire
